// [common/liu_cfg.svh]
// Register offsets, field positions and reset values of the LIU config block.
// Included by the clock decode, the register bank, the assertions and the bench; definitions only.
`ifndef LIU_CFG_SVH
`define LIU_CFG_SVH

// Printed offsets are not all multiples of four: they are register indices
`define IDX_RX_SENSE_CH1_2    8'h08
`define IDX_RX_SENSE_CH3_4    8'h09
`define IDX_RX_SENSE_CH5_6    8'h0A
`define IDX_RX_SENSE_CH9_10   8'h28
`define IDX_RX_SENSE_CH11_12  8'h29
`define IDX_RX_SENSE_CH13_14  8'h2A
`define IDX_MASTER_CLOCK      8'h06
`define IDX_CLOCK_STATUS      8'h30
`define PAIR_STRIDE           8'h20
`define NUM_SENSE_REGS        6

// Receive config field positions
`define EVEN_TURNS_BIT        7
`define EVEN_SEL_HI           6
`define EVEN_SEL_LO           4
`define ODD_TURNS_BIT         3
`define ODD_SEL_HI            2
`define ODD_SEL_LO            0

// Master clock field positions
`define MC_LOOP_BIT           0
`define MC_FAMILY_BIT         1
`define MC_PERIOD_LO          2
`define MC_PERIOD_HI          3

`define SENSE_RESET           8'h00
`define MC_RESET              8'h00

// Expected master clock, kHz
`define T1_BASE_KHZ           16'h0608
`define E1_BASE_KHZ           16'h0800

`endif

// [common/liu_pkg.sv]
// Types shared by the LIU configuration block.
// Does not use liu_cfg.svh; codes are given here.
package liu_pkg;

  typedef enum logic [2:0] {
    SENSE_12DB        = 3'b000,
    SENSE_18DB        = 3'b001,
    MON_14DB_LOSS_30  = 3'b100,
    MON_20DB_LOSS_22  = 3'b101
  } rx_select_t;

  typedef enum logic [1:0] {
    MODE_DIRECT_T1 = 2'b00,
    MODE_DIRECT_E1 = 2'b01,
    MODE_SYNTH     = 2'b10
  } clk_mode_t;

  typedef enum logic [1:0] {
    WR_IDLE = 2'b00,
    WR_RESP = 2'b01
  } wr_state_t;

endpackage : liu_pkg

// [src/clock_select_decode.sv]
// Decodes the master clock selection into expected frequency and mode.
// Assumes the master clock register fields; pure combinational.
`timescale 1ns/1ps
`include "liu_cfg.svh"
module clock_select_decode (
  input  wire logic                   loop_enable,
  input  wire logic                   family_t1,
  input  wire logic [1:0]             period_sel,
  input  wire logic                   direct_t1,
  output logic      [15:0]            expect_khz,
  output liu_pkg::clk_mode_t          mode,
  output logic      [3:0]             multiple
);
  logic [15:0] base;
  always_comb begin
    mode       = liu_pkg::MODE_DIRECT_E1;
    multiple   = 4'h1;
    base       = `E1_BASE_KHZ;
    expect_khz = base;
    if (loop_enable) begin
      base       = family_t1 ? `T1_BASE_KHZ : `E1_BASE_KHZ;
      multiple   = 4'(4'h1 << period_sel);
      expect_khz = 16'(base << period_sel);
      mode       = liu_pkg::MODE_SYNTH;
    end else begin
      // Clock used unmodified; line mode alone fixes the rate
      base       = direct_t1 ? `T1_BASE_KHZ : `E1_BASE_KHZ;
      expect_khz = base;
      mode       = direct_t1 ? liu_pkg::MODE_DIRECT_T1 : liu_pkg::MODE_DIRECT_E1;
    end
  end
endmodule : clock_select_decode

// [src/liu_clock_and_rx_sense_config.sv]
// AXI4-Lite register bank: master clock selection and receive sense config.
// Assumes a single 40 MHz aclk and synchronous active-low aresetn.
//
// Behaviour
// - Loop on: family and period pick rate
// - Loop enable starts synthesiser, else direct
// - Turns bit set selects 1:1 ratio
// - Three-bit select picks sensitivity and gain
// - Codes 000,001,100,101 map to settings
// - Even channel high nibble, odd low
// - Channels 1-6 at 08h, 9-14 at 28h
//
// The AXI4-Lite interface to the registers was decided locally.
`timescale 1ns/1ps
`include "liu_cfg.svh"
module liu_clock_and_rx_sense_config (
  input  wire logic                 aclk,
  input  wire logic                 aresetn,
  input  wire logic [9:0]           s_axi_awaddr,
  input  wire logic [2:0]           s_axi_awprot,
  input  wire logic                 s_axi_awvalid,
  output logic                      s_axi_awready,
  input  wire logic [31:0]          s_axi_wdata,
  input  wire logic [3:0]           s_axi_wstrb,
  input  wire logic                 s_axi_wvalid,
  output logic                      s_axi_wready,
  output logic      [1:0]           s_axi_bresp,
  output logic                      s_axi_bvalid,
  input  wire logic                 s_axi_bready,
  input  wire logic [9:0]           s_axi_araddr,
  input  wire logic [2:0]           s_axi_arprot,
  input  wire logic                 s_axi_arvalid,
  output logic                      s_axi_arready,
  output logic      [31:0]          s_axi_rdata,
  output logic      [1:0]           s_axi_rresp,
  output logic                      s_axi_rvalid,
  input  wire logic                 s_axi_rready,
  input  wire logic                 line_mode_t1,
  output logic                      synth_loop_enable,
  output logic                      clock_family_select,
  output logic      [1:0]           master_period_select,
  output logic      [15:0]          expected_clock_khz,
  output logic      [3:0]           clock_multiple,
  output logic      [11:0]          rx_turns_ratio_one_to_one,
  output logic      [35:0]          rx_sense_monitor_select,
  output logic      [11:0]          rx_monitor_mode,
  output logic      [11:0]          rx_high_sense,
  output logic      [11:0]          rx_high_gain
);

  localparam int NREG = `NUM_SENSE_REGS;
  localparam int NCH  = 2 * NREG;

  typedef struct packed {
    logic                  aw_held;
    logic [7:0]            aw_idx;
    logic                  w_held;
    logic [31:0]           w_data;
    logic                  w_strb0;
    logic                  bvalid;
    logic [1:0]            bresp;
    logic                  rvalid;
    logic [1:0]            rresp;
    logic [31:0]           rdata;
    logic [7:0]            mc;
    logic [NREG-1:0][7:0]  sense;
    logic                  line_meta;
    logic                  line_sync;
  } state_t;

  state_t s_r;
  state_t s_nxt;

  // Register index to sense slot; -1 when not a sense register
  function automatic logic [3:0] sense_slot(input logic [7:0] idx);
    logic [3:0] slot;
    slot = 4'hF;
    for (int i = 0; i < 3; i++) begin
      if (idx == 8'(`IDX_RX_SENSE_CH1_2 + i)) slot = 4'(i);
      if (idx == 8'(`IDX_RX_SENSE_CH1_2 + `PAIR_STRIDE + i)) slot = 4'(i + 3);
    end
    return slot;
  endfunction : sense_slot

  // Byte address to register index; the two low address bits are ignored
  function automatic logic [7:0] addr_to_idx(input logic [9:0] addr);
    return addr[9:2];
  endfunction : addr_to_idx

  function automatic logic mapped(input logic [7:0] idx);
    return (sense_slot(idx) != 4'hF) || (idx == `IDX_MASTER_CLOCK)
           || (idx == `IDX_CLOCK_STATUS);
  endfunction : mapped

  logic [15:0]          exp_khz;
  liu_pkg::clk_mode_t   clk_mode;
  logic [3:0]           mult;

  clock_select_decode u_clk (
    .loop_enable (s_r.mc[`MC_LOOP_BIT]),
    .family_t1   (s_r.mc[`MC_FAMILY_BIT]),
    .period_sel  (s_r.mc[`MC_PERIOD_HI:`MC_PERIOD_LO]),
    .direct_t1   (s_r.line_sync),
    .expect_khz  (exp_khz),
    .mode        (clk_mode),
    .multiple    (mult)
  );

  logic [NCH-1:0][2:0] ch_sel;
  logic [NCH-1:0]      ch_turns;

  genvar g;
  generate
    for (g = 0; g < NREG; g++) begin : g_fields
      // Even channel in the high nibble, odd in the low
      assign ch_turns[2*g]   = s_r.sense[g][`ODD_TURNS_BIT];
      assign ch_sel[2*g]     = s_r.sense[g][`ODD_SEL_HI:`ODD_SEL_LO];
      assign ch_turns[2*g+1] = s_r.sense[g][`EVEN_TURNS_BIT];
      assign ch_sel[2*g+1]   = s_r.sense[g][`EVEN_SEL_HI:`EVEN_SEL_LO];
    end
    for (g = 0; g < NCH; g++) begin : g_dec
      rx_sense_decode u_dec (
        .sel          (ch_sel[g]),
        .monitor_mode (rx_monitor_mode[g]),
        .high_sense   (rx_high_sense[g]),
        .high_gain    (rx_high_gain[g]),
        .sel_valid    ()
      );
    end
  endgenerate

  logic       do_write;
  logic [3:0] wslot;
  logic [7:0] ridx;
  logic [3:0] rslot;

  always_comb begin
    s_nxt = s_r;
    // Line mode strap comes from a pin: two flops before use
    s_nxt.line_meta = line_mode_t1;
    s_nxt.line_sync = s_r.line_meta;

    // Address and data are taken in either order, then held
    if (s_axi_awvalid && s_axi_awready) begin
      s_nxt.aw_held = 1'b1;
      s_nxt.aw_idx  = addr_to_idx(s_axi_awaddr);
    end
    if (s_axi_wvalid && s_axi_wready) begin
      s_nxt.w_held  = 1'b1;
      s_nxt.w_data  = s_axi_wdata;
      s_nxt.w_strb0 = s_axi_wstrb[0];
    end

    do_write = s_r.aw_held && s_r.w_held && !s_r.bvalid;
    wslot    = sense_slot(s_r.aw_idx);
    if (do_write) begin
      s_nxt.aw_held = 1'b0;
      s_nxt.w_held  = 1'b0;
      s_nxt.bvalid  = 1'b1;
      s_nxt.bresp   = mapped(s_r.aw_idx) ? 2'h0 : 2'h2;
      // Only byte lane 0 carries register data
      if (s_r.w_strb0) begin
        if (wslot != 4'hF) begin
          s_nxt.sense[wslot[2:0]] = s_r.w_data[7:0];
        end
        if (s_r.aw_idx == `IDX_MASTER_CLOCK) begin
          s_nxt.mc = s_r.w_data[7:0];
        end
      end
    end
    if (s_r.bvalid && s_axi_bready) begin
      s_nxt.bvalid = 1'b0;
    end

    ridx  = addr_to_idx(s_axi_araddr);
    rslot = sense_slot(ridx);
    if (s_axi_arvalid && s_axi_arready) begin
      s_nxt.rvalid = 1'b1;
      s_nxt.rresp  = 2'h0;
      s_nxt.rdata  = 32'h0000_0000;
      if (rslot != 4'hF) begin
        s_nxt.rdata[7:0] = s_r.sense[rslot[2:0]];
      end else if (ridx == `IDX_MASTER_CLOCK) begin
        s_nxt.rdata[7:0] = s_r.mc;
      end else if (ridx == `IDX_CLOCK_STATUS) begin
        s_nxt.rdata = {6'h00, 2'(clk_mode), mult, exp_khz[15:0], 4'h0};
      end else begin
        s_nxt.rresp = 2'h2;
      end
    end else if (s_r.rvalid && s_axi_rready) begin
      s_nxt.rvalid = 1'b0;
    end

    if (!aresetn) begin
      s_nxt       = '0;
      s_nxt.mc    = `MC_RESET;
      s_nxt.sense = {NREG{`SENSE_RESET}};
    end
  end

  always_ff @(posedge aclk) begin
    s_r <= s_nxt;
  end

  // One write at a time: stall each channel once it holds its half
  assign s_axi_awready = aresetn && !s_r.aw_held && !s_r.bvalid;
  assign s_axi_wready  = aresetn && !s_r.w_held && !s_r.bvalid;
  assign s_axi_bvalid  = s_r.bvalid;
  assign s_axi_bresp   = s_r.bresp;
  assign s_axi_arready = aresetn && !s_r.rvalid;
  assign s_axi_rvalid  = s_r.rvalid;
  assign s_axi_rresp   = s_r.rresp;
  assign s_axi_rdata   = s_r.rdata;

  assign synth_loop_enable    = s_r.mc[`MC_LOOP_BIT];
  assign clock_family_select  = s_r.mc[`MC_FAMILY_BIT];
  assign master_period_select = s_r.mc[`MC_PERIOD_HI:`MC_PERIOD_LO];
  assign expected_clock_khz   = exp_khz;
  assign clock_multiple       = mult;

  always_comb begin
    for (int c = 0; c < NCH; c++) begin
      rx_turns_ratio_one_to_one[c]     = ch_turns[c];
      rx_sense_monitor_select[3*c +: 3] = ch_sel[c];
    end
  end

endmodule : liu_clock_and_rx_sense_config

// [src/rx_sense_decode.sv]
// Decodes one 3-bit receive select code into sensitivity and monitor settings.
// Assumes a code from a receive config register; pure combinational.
`timescale 1ns/1ps
module rx_sense_decode (
  input  wire logic [2:0] sel,
  output logic            monitor_mode,
  output logic            high_sense,
  output logic            high_gain,
  output logic            sel_valid
);
  always_comb begin
    monitor_mode = 1'b0;
    high_sense   = 1'b0;
    high_gain    = 1'b0;
    sel_valid    = 1'b1;
    unique case (sel)
      liu_pkg::SENSE_12DB: begin
      end
      liu_pkg::SENSE_18DB: begin
        high_sense = 1'b1;
      end
      liu_pkg::MON_14DB_LOSS_30: begin
        monitor_mode = 1'b1;
      end
      liu_pkg::MON_20DB_LOSS_22: begin
        monitor_mode = 1'b1;
        high_gain    = 1'b1;
      end
      default: begin
        // Undefined codes fall back to the 12 dB setting
        sel_valid = 1'b0;
      end
    endcase
  end
endmodule : rx_sense_decode

// [verification/liu_cfg_props.sv]
// Port-level assertions for the LIU clock and receive sense config block.
// Assumes one aclk domain with synchronous active-low aresetn; bound below.
`timescale 1ns/1ps
`include "liu_cfg.svh"
module liu_cfg_props (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        synth_loop_enable,
  input wire logic        clock_family_select,
  input wire logic [1:0]  master_period_select,
  input wire logic [15:0] expected_clock_khz,
  input wire logic [3:0]  clock_multiple,
  input wire logic [11:0] rx_turns_ratio_one_to_one,
  input wire logic [35:0] rx_sense_monitor_select,
  input wire logic [11:0] rx_monitor_mode,
  input wire logic [11:0] rx_high_sense,
  input wire logic [11:0] rx_high_gain
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic [11:0] mon_x;
  logic [11:0] sen_x;
  logic [11:0] gain_x;
  always_comb begin
    for (int c = 0; c < 12; c++) begin
      mon_x[c]  = rx_sense_monitor_select[3*c +: 3] inside {3'b100, 3'b101};
      sen_x[c]  = rx_sense_monitor_select[3*c +: 3] == 3'b001;
      gain_x[c] = rx_sense_monitor_select[3*c +: 3] == 3'b101;
    end
  end
  sequence rd_take; s_axi_arvalid && s_axi_arready; endsequence
  sequence rd_answer; s_axi_rvalid; endsequence
  read_answer_a: assert property (rd_take |=> rd_answer)
    else $error("read not answered next cycle");
  bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  reset_zero_a: assert property ($rose(aresetn) |->
    {rx_turns_ratio_one_to_one, rx_sense_monitor_select} == 48'h0)
    else $error("config not zero after reset");
  config_write_a: assert property ($past(aresetn) &&
    $changed({rx_turns_ratio_one_to_one, rx_sense_monitor_select}) |-> $rose(s_axi_bvalid))
    else $error("config changed without a write");
  loop_mult_a: assert property (synth_loop_enable |->
    clock_multiple == (4'h1 << master_period_select))
    else $error("wrong clock multiple");
  loop_rate_a: assert property (synth_loop_enable |-> expected_clock_khz ==
    ((clock_family_select ? `T1_BASE_KHZ : `E1_BASE_KHZ) << master_period_select))
    else $error("wrong synthesised clock rate");
  direct_rate_a: assert property (!synth_loop_enable |-> clock_multiple == 4'h1 &&
    expected_clock_khz inside {`T1_BASE_KHZ, `E1_BASE_KHZ})
    else $error("direct clock not unmodified");
  monitor_map_a: assert property (rx_monitor_mode == mon_x)
    else $error("monitor decode wrong");
  sense_map_a: assert property (rx_high_sense == sen_x && rx_high_gain == gain_x)
    else $error("sense or gain decode wrong");
endmodule : liu_cfg_props

bind liu_clock_and_rx_sense_config liu_cfg_props liu_cfg_props_i (.aclk, .aresetn,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
  .synth_loop_enable, .clock_family_select, .master_period_select, .expected_clock_khz,
  .clock_multiple, .rx_turns_ratio_one_to_one, .rx_sense_monitor_select, .rx_monitor_mode,
  .rx_high_sense, .rx_high_gain);

// [verification/tb.sv]
// Self-checking bench for the LIU config block over AXI4-Lite.
// Assumes liu_cfg.svh on the include path; bench drives every port.
`timescale 1ns/1ps
`include "liu_cfg.svh"
module tb;
  logic aclk, aresetn, awv, awr, wv, wr, bv, bre, arv, arr, rv, rre, lm, sle, cfs;
  logic [9:0] awa, ara;
  logic [31:0] wd, rdata;
  logic [3:0] ws, mult;
  logic [1:0] bresp, rresp, mps;
  logic [15:0] khz;
  logic [11:0] tr, mon, hsen, hg;
  logic [35:0] sel;
  logic [7:0] v;
  logic [15:0] ek;
  logic [3:0] em;
  int n_fail, samples_checked, cyc;
  logic [7:0] ridx [6] = '{`IDX_RX_SENSE_CH1_2, `IDX_RX_SENSE_CH3_4, `IDX_RX_SENSE_CH5_6,
                           `IDX_RX_SENSE_CH9_10, `IDX_RX_SENSE_CH11_12, `IDX_RX_SENSE_CH13_14};
  logic [2:0] codes [4] = '{3'b000, 3'b001, 3'b100, 3'b101};
  liu_clock_and_rx_sense_config liu_clock_and_rx_sense_config_i (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awa), .s_axi_awprot(3'h0), .s_axi_awvalid(awv), .s_axi_awready(awr),
    .s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_wvalid(wv), .s_axi_wready(wr),
    .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(bre), .s_axi_araddr(ara),
    .s_axi_arprot(3'h0), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rre), .line_mode_t1(lm),
    .synth_loop_enable(sle), .clock_family_select(cfs), .master_period_select(mps),
    .expected_clock_khz(khz), .clock_multiple(mult), .rx_turns_ratio_one_to_one(tr),
    .rx_sense_monitor_select(sel), .rx_monitor_mode(mon), .rx_high_sense(hsen),
    .rx_high_gain(hg));
  initial begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end
  function automatic logic [7:0] val(int k);
    return 8'hA5 ^ 8'(k * 8'h13);
  endfunction : val
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  // Waits until r is high just after an edge; caller then takes the next edge
  task automatic wt(ref logic r);
    #1;
    while (r !== 1'b1) begin
      @(posedge aclk);
      #1;
    end
  endtask : wt
  task automatic axw(input logic [7:0] i, input logic [7:0] d, input logic [3:0] s,
                     input logic [1:0] er);
    awa <= {i, 2'b00};
    wd  <= {24'h0, d};
    ws  <= s;
    awv <= 1'b1;
    wv  <= 1'b1;
    bre <= 1'b1;
    fork
      begin wt(awr); @(posedge aclk); awv <= 1'b0; end
      begin wt(wr); @(posedge aclk); wv <= 1'b0; end
    join
    wt(bv);
    chk("bresp", {30'h0, er}, {30'h0, bresp});
    // Ready stays up; dropping it here would clash with the next call
    @(posedge aclk);
  endtask : axw
  task automatic axr(input logic [7:0] i, input logic [31:0] d, input logic [1:0] er);
    ara <= {i, 2'b00};
    arv <= 1'b1;
    rre <= 1'b1;
    wt(arr);
    @(posedge aclk);
    arv <= 1'b0;
    wt(rv);
    chk("rdata", d, rdata);
    chk("rresp", {30'h0, er}, {30'h0, rresp});
    @(posedge aclk);
  endtask : axr
  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : give_verdict
  // Whole run needs a few hundred cycles; far above that means a hang
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      give_verdict();
    end
  end
  initial begin
    {aresetn, awv, wv, bre, arv, rre, awa, ara, wd, ws} = '0;
    lm = 1'b1;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    foreach (ridx[k]) axr(ridx[k], 8'h00, 2'b00);
    $display("reset value test done");
    foreach (ridx[k]) begin
      v = val(k);
      axw(ridx[k], v, 4'hF, 2'b00);
      chk("turns", {30'h0, v[7], v[3]}, {30'h0, tr[2*k +: 2]});
      chk("select", {26'h0, v[6:4], v[2:0]}, {26'h0, sel[6*k +: 6]});
    end
    foreach (ridx[k]) axr(ridx[k], val(k), 2'b00);
    axw(ridx[0], 8'h00, 4'hE, 2'b00);
    axr(ridx[0], val(0), 2'b00);
    axw(8'h0B, 8'h5A, 4'hF, 2'b10);
    axr(8'h2B, 8'h00, 2'b10);
    axr(ridx[2], val(2), 2'b00);
    $display("register map test done");
    foreach (codes[c]) begin
      axw(ridx[0], {1'b1, codes[c], 1'b0, codes[c]}, 4'hF, 2'b00);
      chk("turns", 32'h2, {30'h0, tr[1:0]});
      chk("monitor", {30'h0, {2{codes[c][2]}}}, {30'h0, mon[1:0]});
      chk("sense", {30'h0, {2{codes[c] == 3'b001}}}, {30'h0, hsen[1:0]});
      chk("gain", {30'h0, {2{codes[c] == 3'b101}}}, {30'h0, hg[1:0]});
    end
    $display("select code test done");
    for (int m = 0; m < 16; m++) begin
      lm <= ~m[1];
      axw(`IDX_MASTER_CLOCK, 8'(m), 4'hF, 2'b00);
      if (m[0]) begin
        chk("khz", ((m[1] ? `T1_BASE_KHZ : `E1_BASE_KHZ) << m[3:2]), {16'h0, khz});
        chk("multiple", 32'h1 << m[3:2], {28'h0, mult});
      end else begin
        chk("khz", (m[1] ? `E1_BASE_KHZ : `T1_BASE_KHZ), {16'h0, khz});
        chk("multiple", 32'h1, {28'h0, mult});
      end
      em = m[0] ? 4'(4'h1 << m[3:2]) : 4'h1;
      ek = m[0] ? 16'((m[1] ? `T1_BASE_KHZ : `E1_BASE_KHZ) << m[3:2])
                : (m[1] ? `E1_BASE_KHZ : `T1_BASE_KHZ);
      chk("mc fields", {28'h0, m[3:0]}, {28'h0, mps, cfs, sle});
      axr(`IDX_MASTER_CLOCK, 8'(m), 2'b00);
      axr(`IDX_CLOCK_STATUS, {6'h00, (m[0] ? 2'h2 : {1'b0, m[1]}), em, ek, 4'h0}, 2'b00);
    end
    $display("master clock test done");
    give_verdict();
  end
endmodule : tb
